// *** hw/bmr_pkg.sv ***
// constants for the backup monitor register bank
package bmr_pkg;
    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] BMR_ADDR_TIMER_LOW = 8'h08;
    localparam logic [7:0] BMR_ADDR_CURRENT = 8'h09;
    localparam logic [7:0] BMR_ADDR_BUS_VOLT = 8'h0A;
    localparam logic [7:0] BMR_ADDR_OVP = 8'h0B;
    localparam logic [7:0] BMR_ADDR_IN_VOLT = 8'h0C;
    localparam logic [7:0] BMR_ADDR_STR_VOLT = 8'h0D;
    localparam logic [7:0] BMR_ADDR_MASK = 8'h0E;
    localparam logic [7:0] BMR_ADDR_FLAGS = 8'h0F;
    // ****************************************
    // reset values and fields
    // ****************************************
    localparam logic [7:0] BMR_RST_ZERO = 8'h00;
    localparam logic [4:0] BMR_RST_OVP = 5'h1D;
    localparam logic [7:0] BMR_RST_MASK = 8'h00;
    localparam int BMR_OVP_W = 5;
    localparam int BMR_CUR_W = 6;
    localparam int BMR_CUR_LSB = 2;
    localparam int BMR_ESR_BIT = 0;
    localparam int BMR_EV_IN_OVP = 7;
    localparam int BMR_EV_REV_BLK = 4;
    localparam int BMR_EV_MEAS_DONE = 3;
    localparam int BMR_EV_ADC_DONE = 2;
    // esr threshold in mV by code
    localparam logic [7:0] BMR_ESR_MV_STEP = 8'h32;
    localparam logic [7:0] BMR_ESR_CODE_ONE = 8'h01;
    // ****************************************
    // other reset and reserved values
    // ****************************************
    localparam logic [5:0] BMR_RST_CUR = 6'h00;
    localparam logic BMR_RST_ESR = 1'b0;
    localparam logic [7:0] BMR_RST_FLAGS = 8'h00;
    localparam logic BMR_RST_EDGE = 1'b0;
    localparam logic BMR_RESV_BIT = 1'b0;
    localparam logic [2:0] BMR_OVP_RESV = 3'h0;
endpackage

// *** hw/bmr_bank.sv ***
// backup monitor register bank with event flags and interrupt pin
`timescale 1ns/1ns
module bmr_bank
    import bmr_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] discharge_timer_low_bits,
    input wire logic [5:0] input_current_result_bits,
    input wire logic [7:0] bus_voltage_in,
    input wire logic [7:0] input_voltage_in,
    input wire logic [7:0] storage_voltage_in,
    input wire logic [7:0] esr_step_mv,
    input wire logic [1:0] esr_threshold_code,
    input wire logic results_valid,
    input wire logic [7:0] event_raw,
    input wire logic in_ovp_enable,
    input wire logic reverse_blocking_protection,
    input wire logic meas_enable_bit,
    input wire logic adc_enable_bit,
    output logic meas_start,
    output logic adc_start,
    output logic [4:0] storage_overvoltage_threshold,
    output logic [7:0] interrupt_mask,
    output logic [7:0] event_flags,
    output logic int_n
);
    // ****************************************
    // declarations
    // ****************************************
    // captured results
    logic [7:0] timer_reg;
    logic [7:0] timer_next;
    logic [5:0] cur_reg;
    logic [5:0] cur_next;
    logic esr_reg;
    logic esr_next;
    logic [7:0] bus_reg;
    logic [7:0] bus_next;
    logic [7:0] vin_reg;
    logic [7:0] vin_next;
    logic [7:0] str_reg;
    logic [7:0] str_next;
    // host settings
    logic [4:0] ovp_reg;
    logic [4:0] ovp_next;
    logic [7:0] mask_reg;
    logic [7:0] mask_next;
    // flags and edge history
    logic [7:0] flag_reg;
    logic [7:0] flag_next;
    logic meas_q_reg;
    logic meas_q_next;
    logic adc_q_reg;
    logic adc_q_next;
    // read path
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    // combinational helpers
    logic [7:0] ev_gated;
    logic [7:0] esr_limit;
    logic esr_over;
    logic wr_ovp;
    logic wr_mask;
    logic wr_flags;

    // ****************************************
    // helper functions
    // ****************************************
    // esr threshold in mV from the 2-bit code
    function automatic logic [7:0] esr_mv(input logic [1:0] code);
        esr_mv = 8'((8'(code) + BMR_ESR_CODE_ONE) * BMR_ESR_MV_STEP);
    endfunction

    // offset match for the write decode
    function automatic logic addr_hit(input logic [7:0] a,
        input logic [7:0] target);
        addr_hit = (a == target);
    endfunction

    // ****************************************
    // event gating
    // ****************************************
    always_comb
    begin
        ev_gated = event_raw;
        ev_gated[BMR_EV_IN_OVP] = event_raw[BMR_EV_IN_OVP]
            & in_ovp_enable;
        ev_gated[BMR_EV_REV_BLK] = event_raw[BMR_EV_REV_BLK]
            & reverse_blocking_protection;
    end

    // ****************************************
    // write decode
    // ****************************************
    always_comb
    begin
        wr_ovp = reg_wr && addr_hit(reg_addr, BMR_ADDR_OVP);
        wr_mask = reg_wr && addr_hit(reg_addr, BMR_ADDR_MASK);
        wr_flags = reg_wr && addr_hit(reg_addr, BMR_ADDR_FLAGS);
    end

    // ****************************************
    // conversion results
    // ****************************************
    always_comb
    begin
        timer_next = timer_reg;
        cur_next = cur_reg;
        esr_next = esr_reg;
        bus_next = bus_reg;
        vin_next = vin_reg;
        str_next = str_reg;
        esr_limit = esr_mv(esr_threshold_code);
        esr_over = (esr_step_mv > esr_limit);
        if (results_valid)
        begin
            timer_next = discharge_timer_low_bits;
            cur_next = input_current_result_bits;
            esr_next = esr_over;
            bus_next = bus_voltage_in;
            vin_next = input_voltage_in;
            str_next = storage_voltage_in;
        end
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            timer_reg <= BMR_RST_ZERO;
            cur_reg <= BMR_RST_CUR;
            esr_reg <= BMR_RST_ESR;
            bus_reg <= BMR_RST_ZERO;
            vin_reg <= BMR_RST_ZERO;
            str_reg <= BMR_RST_ZERO;
        end
        else
        begin
            timer_reg <= timer_next;
            cur_reg <= cur_next;
            esr_reg <= esr_next;
            bus_reg <= bus_next;
            vin_reg <= vin_next;
            str_reg <= str_next;
        end
    end

    // ****************************************
    // over-voltage threshold field
    // ****************************************
    always_comb
    begin
        ovp_next = ovp_reg;
        if (wr_ovp)
        begin
            ovp_next = reg_wdata[BMR_OVP_W-1:0];
        end
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            ovp_reg <= BMR_RST_OVP;
        end
        else
        begin
            ovp_reg <= ovp_next;
        end
    end

    // ****************************************
    // interrupt mask
    // ****************************************
    always_comb
    begin
        mask_next = mask_reg;
        if (wr_mask)
        begin
            mask_next = reg_wdata;
        end
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            mask_reg <= BMR_RST_MASK;
        end
        else
        begin
            mask_reg <= mask_next;
        end
    end

    // ****************************************
    // event flags
    // ****************************************
    always_comb
    begin
        flag_next = flag_reg;
        if (wr_flags)
        begin
            flag_next = flag_reg & ~reg_wdata;
        end
        // a new event wins over a clear in the same cycle
        flag_next = flag_next | ev_gated;
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            flag_reg <= BMR_RST_FLAGS;
        end
        else
        begin
            flag_reg <= flag_next;
        end
    end

    // ****************************************
    // measurement start edge
    // ****************************************
    always_comb
    begin
        meas_q_next = meas_enable_bit;
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            meas_q_reg <= BMR_RST_EDGE;
        end
        else
        begin
            meas_q_reg <= meas_q_next;
        end
    end

    // ****************************************
    // conversion start edge
    // ****************************************
    always_comb
    begin
        adc_q_next = adc_enable_bit;
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            adc_q_reg <= BMR_RST_EDGE;
        end
        else
        begin
            adc_q_reg <= adc_q_next;
        end
    end

    // ****************************************
    // read data
    // ****************************************
    always_comb
    begin
        rdata_next = rdata_reg;
        if (reg_rd)
        begin
            case (reg_addr)
                BMR_ADDR_TIMER_LOW: rdata_next = timer_reg;
                BMR_ADDR_CURRENT:
                    rdata_next = {cur_reg, BMR_RESV_BIT, esr_reg};
                BMR_ADDR_BUS_VOLT: rdata_next = bus_reg;
                BMR_ADDR_OVP:
                    rdata_next = {BMR_OVP_RESV, ovp_reg};
                BMR_ADDR_IN_VOLT: rdata_next = vin_reg;
                BMR_ADDR_STR_VOLT: rdata_next = str_reg;
                BMR_ADDR_MASK: rdata_next = mask_reg;
                BMR_ADDR_FLAGS: rdata_next = flag_reg;
                default: rdata_next = BMR_RST_ZERO;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            rdata_reg <= BMR_RST_ZERO;
        end
        else
        begin
            rdata_reg <= rdata_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign meas_start = meas_enable_bit & ~meas_q_reg;
    assign adc_start = adc_enable_bit & ~adc_q_reg;
    assign reg_rdata = rdata_reg;
    assign storage_overvoltage_threshold = ovp_reg;
    assign interrupt_mask = mask_reg;
    assign event_flags = flag_reg;
    // low while any unmasked flag is set
    assign int_n = ~|(flag_reg & ~mask_reg);
endmodule

// *** tb/bmr_bank_props.sv ***
// port assertions for the register bank
`timescale 1ns/1ns
module bmr_bank_props
    import bmr_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] event_raw,
    input wire logic in_ovp_enable,
    input wire logic adc_enable_bit,
    input wire logic adc_start,
    input wire logic [4:0] storage_overvoltage_threshold,
    input wire logic [7:0] interrupt_mask,
    input wire logic [7:0] event_flags,
    input wire logic int_n
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    int_pin_a: assert property
        (int_n == ~|(event_flags & ~interrupt_mask)) else $error("int pin");
    mask_wr_a: assert property (reg_wr && reg_addr == 8'h0E
        |=> interrupt_mask == $past(reg_wdata)) else $error("mask write");
    mask_hold_a: assert property (!(reg_wr && reg_addr == 8'h0E)
        |=> $stable(interrupt_mask)) else $error("mask changed");
    ovp_wr_a: assert property (reg_wr && reg_addr == 8'h0B
        |=> storage_overvoltage_threshold == $past(reg_wdata[4:0]))
        else $error("ovp write");
    adc_edge_a: assert property
        (adc_start == $rose(adc_enable_bit)) else $error("adc start");
    flag_hold_a: assert property (!(reg_wr && reg_addr == 8'h0F)
        |=> (event_flags & $past(event_flags)) == $past(event_flags))
        else $error("flag lost");
    flag_set_a: assert property
        (event_raw[6] |=> event_flags[6]) else $error("flag not set");
    ovp_gate_a: assert property
        (!in_ovp_enable && !event_flags[7] |=> !event_flags[7])
        else $error("ovp gate");
endmodule

// *** tb/bmr_afe.sv ***
// front end model answering conversion starts
`timescale 1ns/1ns
module bmr_afe
(
    input wire logic core_clk,
    input wire logic adc_start,
    output logic results_valid,
    output logic adc_done
);
    int cnt = 0;
    always @(posedge core_clk)
        cnt <= adc_start ? 4 : (cnt > 0 ? cnt - 1 : 0);
    assign results_valid = (cnt == 1);
    assign adc_done = (cnt == 1);
endmodule

// *** tb/tb.sv ***
// self-checking bench for the register bank
`timescale 1ns/1ns
module tb;
    logic core_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, adc_done, int_n;
    logic in_ovp_enable = 0, reverse_blocking_protection = 0;
    logic meas_enable_bit = 0, adc_enable_bit = 0, results_valid;
    logic meas_start, adc_start;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, ev = 0, esr = 8'h65;
    logic [7:0] event_raw, interrupt_mask, event_flags;
    logic [4:0] storage_overvoltage_threshold;
    logic [1:0] code = 2'h1;
    int err_count = 0, comparisons = 0, cycles = 0;
    assign event_raw = {ev[7:3], adc_done, ev[1:0]};
    always #20 core_clk = ~core_clk;
    bmr_afe i_bmr_afe (.core_clk, .adc_start, .results_valid, .adc_done);
    bmr_bank i_bmr_bank (.core_clk, .reset, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata, .reg_rdata, .discharge_timer_low_bits(8'h81),
        .input_current_result_bits(6'h2A), .bus_voltage_in(8'hFF),
        .input_voltage_in(8'h40), .storage_voltage_in(8'hFF),
        .esr_step_mv(esr), .esr_threshold_code(code), .results_valid,
        .event_raw, .in_ovp_enable, .reverse_blocking_protection,
        .meas_enable_bit, .adc_enable_bit, .meas_start, .adc_start,
        .storage_overvoltage_threshold, .interrupt_mask, .event_flags, .int_n);
    task automatic chk(input logic [7:0] g, e);
        comparisons++;
        if (g !== e)
        begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(negedge core_clk);
        {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, e);
        @(negedge core_clk);
        {reg_rd, reg_addr} = {1'b1, a};
        @(negedge core_clk);
        reg_rd = 1'b0;
        chk(reg_rdata, e);
    endtask
    task automatic stop_test();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge core_clk)
        if (++cycles > 1000)
        begin
            err_count++;
            stop_test();
        end
    initial
    begin
        repeat (10) @(negedge core_clk);
        reset = 1'b0;
        for (int a = 8; a < 16; a++)
            rd(8'(a), (a == 11) ? 8'h1D : 8'h00);
        $display("reset test done");
        wr(8'h0E, 8'hA5);
        rd(8'h0E, 8'hA5);
        wr(8'h0B, 8'hFF);
        rd(8'h0B, 8'h1F);
        wr(8'h0A, 8'h77);
        rd(8'h0A, 8'h00);
        $display("write test done");
        adc_enable_bit = 1'b1;
        repeat (8) @(negedge core_clk);
        rd(8'h08, 8'h81);
        rd(8'h0A, 8'hFF);
        rd(8'h09, 8'hA9);
        rd(8'h0C, 8'h40);
        rd(8'h0D, 8'hFF);
        rd(8'h0F, 8'h04);
        chk({7'h0, int_n}, 8'h01);
        $display("conversion test done");
        ev = 8'hD0;
        @(negedge core_clk);
        ev = 8'h00;
        rd(8'h0F, 8'h44);
        chk({7'h0, int_n}, 8'h00);
        {in_ovp_enable, reverse_blocking_protection, ev} = {2'b11, 8'hD0};
        @(negedge core_clk);
        ev = 8'h00;
        rd(8'h0F, 8'hD4);
        wr(8'h0F, 8'hFF);
        rd(8'h0F, 8'h00);
        chk({7'h0, int_n}, 8'h01);
        $display("event test done");
        adc_enable_bit = 1'b0;
        code = 2'h3;
        @(negedge core_clk);
        adc_enable_bit = 1'b1;
        repeat (8) @(negedge core_clk);
        rd(8'h09, 8'hA8);
        rd(8'h0F, 8'h04);
        meas_enable_bit = 1'b1;
        #5 chk({7'h0, meas_start}, 8'h01);
        @(negedge core_clk);
        chk({7'h0, meas_start}, 8'h00);
        meas_enable_bit = 1'b0;
        @(negedge core_clk);
        $display("start test done");
        stop_test();
    end
endmodule
bind bmr_bank bmr_bank_props i_bmr_bank_props (.core_clk, .reset, .reg_wr,
    .reg_addr, .reg_wdata, .event_raw, .in_ovp_enable, .adc_enable_bit,
    .adc_start, .storage_overvoltage_threshold, .interrupt_mask,
    .event_flags, .int_n);
